/* uacc_dbnc_if.sv */
// Purpose: Carrier between the register bank and the fixture delay timer
// Assumes: Single clock domain
// Notes: Request is the raw auto-detect assert; held is the delayed version
`timescale 1ns/1ps

interface uacc_dbnc_if;
  logic request;
  logic [1:0] select;
  logic held;

  modport bank (output request, output select, input held);
  modport timer (input request, input select, output held);
endinterface : uacc_dbnc_if

/* uacc_fixture_delay.sv */
// Purpose: Delays assertion of the fixture output by the chosen debounce time
// Assumes: Request comes from same-clock logic
// Notes: Release is immediate; only assertion is delayed
`timescale 1ns/1ps

module uacc_fixture_delay #(
  parameter int SEL0_CYC = uacc_pkg::DBNC_SEL0_CYC,
  parameter int SEL1_CYC = uacc_pkg::DBNC_SEL1_CYC,
  parameter int SEL2_CYC = uacc_pkg::DBNC_SEL2_CYC,
  parameter int SEL3_CYC = uacc_pkg::DBNC_SEL3_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  uacc_dbnc_if.timer dbnc
);

  typedef struct packed {
    logic [uacc_pkg::DBNC_CNT_W-1:0] count;
    logic held;
  } uacc_dly_state_t;

  uacc_dly_state_t state;
  uacc_dly_state_t next_state;
  logic [uacc_pkg::DBNC_CNT_W-1:0] limit;

  // ==========================================================================
  // Delay counter
  always_comb begin
    case (dbnc.select)
      2'h0: limit = uacc_pkg::DBNC_CNT_W'(SEL0_CYC);
      2'h1: limit = uacc_pkg::DBNC_CNT_W'(SEL1_CYC);
      2'h2: limit = uacc_pkg::DBNC_CNT_W'(SEL2_CYC);
      default: limit = uacc_pkg::DBNC_CNT_W'(SEL3_CYC);
    endcase
    next_state = state;
    if (!dbnc.request) begin
      next_state.count = '0;
      next_state.held = 1'b0;
    end else if (state.count >= limit - 1'b1) begin
      next_state.held = 1'b1; // R17
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dbnc.held = state.held;

endmodule : uacc_fixture_delay

/* uacc_host.sv */
// Purpose: Host model on the register port
// Assumes: Strobes launched 1 ns after the rising edge
// Notes: Released lines are inverted so stale values never match
`timescale 1ns/1ps

module uacc_host (
  input logic clk_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic rd_out,
  input logic [7:0] rdata_in
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    wdata_out = ~d;
    addr_out = ~a;
  endtask : wr_reg
  // Reading an event register is the only way the host clears it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd_reg
endmodule : uacc_host

/* uacc_pkg.sv */
// Purpose: Shared constants for the accessory/charger control register bank
// Assumes: 250 MHz core clock
// Notes: Offsets are byte register addresses

package uacc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ACC_EVENT_FLAGS_ADDR = 8'h01;
  localparam logic [7:0] CHG_EVENT_FLAGS_ADDR = 8'h03;
  localparam logic [7:0] ACC_EVENT_MASK_ADDR = 8'h07;
  localparam logic [7:0] CHG_EVENT_MASK_ADDR = 8'h09;
  localparam logic [7:0] DEBOUNCE_OVERRIDE_ADDR = 8'h0E;
  localparam logic [7:0] CHARGE_TIMER_ADDR = 8'h0F;
  localparam logic [7:0] CHARGER_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] CHARGE_VOLTAGE_ADDR = 8'h11;
  localparam logic [7:0] CHARGE_CURRENT_ADDR = 8'h12;

  // ==========================================================================
  // Field positions
  localparam int CHG_KIND_CHANGED_BIT = 0;
  localparam int DBNC_SEL_LSB = 4;
  localparam int LAMP_OVR_LSB = 2;
  localparam int FIXTURE_OVR_LSB = 0;
  localparam int SPARE_CTRL_LSB = 6;
  localparam int TIMEOUT_SEL_LSB = 4;
  localparam int RAPID_CHARGE_BIT = 7;
  localparam int HOST_CHG_EN_BIT = 6;
  localparam int CURRENT_RANGE_BIT = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] EVENT_MASK_RST = 8'h00;
  localparam logic [7:0] DEBOUNCE_OVERRIDE_RST = 8'h00;
  localparam logic [2:0] TIMEOUT_SEL_RST = 3'h2;
  localparam logic RAPID_CHARGE_RST = 1'b1;
  localparam logic HOST_CHG_EN_RST = 1'b1;
  localparam logic [3:0] VOLTAGE_SEL_RST = 4'h0;
  localparam logic CURRENT_RANGE_RST = 1'b1;
  localparam logic [3:0] CURRENT_HIGH_RST = 4'h5;
  // Read-only reserved fields
  localparam logic TIMER_SPARE_HI = 1'b0;
  localparam logic [3:0] TIMER_SPARE_LO = 4'h4;
  localparam logic [5:0] ENABLE_SPARE = 6'h14;
  localparam logic [3:0] VOLTAGE_SPARE = 4'hA;
  localparam logic [2:0] CURRENT_SPARE = 3'h0;

  // ==========================================================================
  // Field encodings
  localparam logic [1:0] OVR_AUTO = 2'h0;
  localparam logic [1:0] OVR_ONE = 2'h1;
  localparam logic [2:0] TIMEOUT_6H_CODE = 3'h3;
  localparam logic [2:0] TIMEOUT_7H_CODE = 3'h4;
  localparam logic [2:0] TIMEOUT_OFF_CODE = 3'h7;
  localparam logic [3:0] TIMEOUT_5H = 4'h5;
  localparam logic [3:0] TIMEOUT_6H = 4'h6;
  localparam logic [3:0] TIMEOUT_7H = 4'h7;
  localparam logic [2:0] KIND_USB_PORT = 3'h1;
  localparam logic [2:0] KIND_AUTO_LO = 3'h2;
  localparam logic [2:0] KIND_AUTO_HI = 3'h5;
  localparam logic [12:0] CV_DEFAULT_MV = 13'd4200;
  localparam logic [12:0] CV_LOW_BASE_MV = 13'd4000;
  localparam logic [12:0] CV_HIGH_BASE_MV = 13'd4220;
  localparam logic [12:0] CV_MAX_MV = 13'd4350;
  localparam logic [12:0] CV_STEP_MV = 13'd20;
  localparam logic [3:0] CV_LOW_LAST = 4'hA;
  localparam logic [3:0] CV_HIGH_FIRST = 4'hB;
  localparam logic [3:0] CV_MAX_CODE = 4'hF;
  localparam logic [9:0] CURRENT_TRICKLE_MA = 10'd90;
  localparam logic [9:0] CURRENT_BASE_MA = 10'd200;
  localparam logic [9:0] CURRENT_STEP_MA = 10'd50;

  // ==========================================================================
  // Debounce timing
  localparam int CLK_MHZ = 250;
  localparam int DBNC_SEL0_CYC = 500 * CLK_MHZ;
  localparam int DBNC_SEL1_CYC = 10000 * CLK_MHZ;
  localparam int DBNC_SEL2_CYC = 25000 * CLK_MHZ;
  localparam int DBNC_SEL3_CYC = 38620 * CLK_MHZ;
  localparam int DBNC_CNT_W = 24;

endpackage : uacc_pkg

/* uacc_regs.sv */
// Purpose: Event, mask and charger control register bank of the connector interface device
// Assumes: Register port and status inputs all run on ref_clk_in
// Notes: Read data appear one cycle after the read strobe
//
// Contract
// R1: Each accessory event flag sets when its accessory status bit changes.
// R2: Reading an event flag register clears all its bits.
// R3: Interrupt active while any unmasked accessory event flag is set.
// R4: Charger event flags set on charger status changes and raise the interrupt.
// R5: Charger event bit 0 sets when the charger kind code changes.
// R6: Mask bit 0 suppresses, 1 allows; adc change mask resets to 0.
// R7: Debounce select 00/01/10/11 gives 0.5, 10, 25, 38.62 ms.
// R8: Lamp override: 00 auto, 01 drive low, 10/11 high impedance.
// R9: Fixture override: 00 auto, 01 high impedance, 10/11 drive low.
// R10: Timeout select 011 6h, 100 7h, 111 off, others 5h; resets 010.
// R11: Rapid charge bit 0 keeps prequalification; 1, the reset value, allows fast charge.
// R12: Charger on when host enable, detection idle and kind code 010 to 101.
// R13: With usb compliance flag low, kind code 001 also enables charger.
// R14: Voltage code maps to 4.20, 4.00-4.18, 4.22-4.28, 4.35 volts.
// R15: Current range bit 0 limits to 90mA; 1 uses the high field.
// R16: High current field gives 200 to 950mA in 50mA steps; resets 0101.
// R17: Fixture assertion delayed by the selected debounce time.
// R18: All interrupt sources masked after reset.
// R19: Host read clears flags; interrupt drops unless other unmasked flags remain.
// R20: Reserved read-only fields return defaults and ignore writes.
`timescale 1ns/1ps

module uacc_regs #(
  parameter int DBNC0_CYC = uacc_pkg::DBNC_SEL0_CYC,
  parameter int DBNC1_CYC = uacc_pkg::DBNC_SEL1_CYC,
  parameter int DBNC2_CYC = uacc_pkg::DBNC_SEL2_CYC,
  parameter int DBNC3_CYC = uacc_pkg::DBNC_SEL3_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,

  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,

  input wire logic [7:0] accessory_status_a_in,
  input wire logic [7:0] accessory_status_c_in,
  input wire logic [2:0] charger_kind_code_in,
  input wire logic charger_detection_running_in,
  input wire logic usb_compliance_flag_in,
  input wire logic lamp_auto_low_in,
  input wire logic fixture_auto_low_in,

  output logic irq_n_out,
  output logic lamp_out,
  output logic lamp_oe_n_out,
  output logic fixture_out,
  output logic fixture_oe_n_out,

  output logic [1:0] adc_debounce_select_out,
  output logic charger_enable_out,
  output logic fast_charge_permit_out,
  output logic [3:0] fast_charge_timeout_hours_out,
  output logic fast_charge_timer_off_out,
  output logic [12:0] regulation_millivolts_out,
  output logic [9:0] charge_current_ma_out
);

  typedef struct packed {
    logic primed;

    logic [7:0] prev_status_a;
    logic [7:0] prev_status_c;
    logic [2:0] prev_kind;

    logic [7:0] accessory_event_flags;
    logic [7:0] charger_event_flags;

    logic [7:0] accessory_event_mask;
    logic [7:0] charger_event_mask;

    logic [1:0] spare_ctrl;
    logic [1:0] adc_debounce_select;

    logic [1:0] status_lamp_override;
    logic [1:0] fixture_output_override;

    logic [2:0] fast_charge_timeout_select;

    logic rapid_charge_enable;
    logic host_charger_enable;

    logic [3:0] regulation_voltage_select;

    logic charge_current_range_bit;
    logic [3:0] charge_current_high_field;

    logic [7:0] rdata;

    logic irq;
    logic charger_on;

    logic [3:0] timeout_hours;
    logic [12:0] cv_mv;
    logic [9:0] current_ma;
  } uacc_bank_state_t;

  uacc_bank_state_t state;
  uacc_bank_state_t next_state;
  uacc_dbnc_if dbnc ();

  logic [7:0] acc_set;
  logic [7:0] chg_set;
  logic [7:0] read_value;
  logic acc_read;
  logic chg_read;
  logic kind_auto;

  // ==========================================================================
  // Fixture debounce timer
  assign dbnc.request = fixture_auto_low_in;
  assign dbnc.select = state.adc_debounce_select; // R7

  uacc_fixture_delay #(
    .SEL0_CYC(DBNC0_CYC),
    .SEL1_CYC(DBNC1_CYC),
    .SEL2_CYC(DBNC2_CYC),
    .SEL3_CYC(DBNC3_CYC)
  ) u_fixture_delay (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .dbnc(dbnc.timer)
  );

  // ==========================================================================
  // Read multiplexer
  always_comb begin
    case (reg_addr_in)
      uacc_pkg::ACC_EVENT_FLAGS_ADDR: read_value = state.accessory_event_flags;
      uacc_pkg::CHG_EVENT_FLAGS_ADDR: read_value = state.charger_event_flags;
      uacc_pkg::ACC_EVENT_MASK_ADDR: read_value = state.accessory_event_mask;
      uacc_pkg::CHG_EVENT_MASK_ADDR: read_value = state.charger_event_mask;

      uacc_pkg::DEBOUNCE_OVERRIDE_ADDR: begin
        read_value = {state.spare_ctrl, state.adc_debounce_select,
                      state.status_lamp_override, state.fixture_output_override};
      end

      uacc_pkg::CHARGE_TIMER_ADDR: begin
        read_value = {uacc_pkg::TIMER_SPARE_HI, state.fast_charge_timeout_select,
                      uacc_pkg::TIMER_SPARE_LO}; // R20
      end

      uacc_pkg::CHARGER_ENABLE_ADDR: begin
        read_value = {state.rapid_charge_enable, state.host_charger_enable,
                      uacc_pkg::ENABLE_SPARE}; // R20
      end

      uacc_pkg::CHARGE_VOLTAGE_ADDR: begin
        read_value = {uacc_pkg::VOLTAGE_SPARE, state.regulation_voltage_select}; // R20
      end

      uacc_pkg::CHARGE_CURRENT_ADDR: begin
        read_value = {uacc_pkg::CURRENT_SPARE, state.charge_current_range_bit,
                      state.charge_current_high_field}; // R20
      end

      default: read_value = 8'h00;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    acc_read = reg_rd_in && (reg_addr_in == uacc_pkg::ACC_EVENT_FLAGS_ADDR);
    chg_read = reg_rd_in && (reg_addr_in == uacc_pkg::CHG_EVENT_FLAGS_ADDR);

    // First cycle after reset only learns the status; avoids false events from reset zeros
    next_state.primed = 1'b1;
    next_state.prev_status_a = accessory_status_a_in;
    next_state.prev_status_c = accessory_status_c_in;
    next_state.prev_kind = charger_kind_code_in;
    if (state.primed) begin
      acc_set = accessory_status_a_in ^ state.prev_status_a; // R1
      chg_set = {accessory_status_c_in[7:1] ^ state.prev_status_c[7:1], 1'b0}; // R4
      chg_set[uacc_pkg::CHG_KIND_CHANGED_BIT] = charger_kind_code_in != state.prev_kind; // R5
    end else begin
      acc_set = 8'h00;
      chg_set = 8'h00;
    end

    // Set wins over a read clear in the same cycle
    next_state.accessory_event_flags = (acc_read ? 8'h00 : state.accessory_event_flags) | acc_set; // R2
    next_state.charger_event_flags = (chg_read ? 8'h00 : state.charger_event_flags) | chg_set; // R2

    if (reg_rd_in) begin
      next_state.rdata = read_value;
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        uacc_pkg::ACC_EVENT_MASK_ADDR: next_state.accessory_event_mask = reg_wdata_in; // R6
        uacc_pkg::CHG_EVENT_MASK_ADDR: next_state.charger_event_mask = reg_wdata_in; // R6

        uacc_pkg::DEBOUNCE_OVERRIDE_ADDR: begin
          next_state.spare_ctrl = reg_wdata_in[uacc_pkg::SPARE_CTRL_LSB +: 2];
          next_state.adc_debounce_select = reg_wdata_in[uacc_pkg::DBNC_SEL_LSB +: 2]; // R7
          next_state.status_lamp_override = reg_wdata_in[uacc_pkg::LAMP_OVR_LSB +: 2];
          next_state.fixture_output_override = reg_wdata_in[uacc_pkg::FIXTURE_OVR_LSB +: 2];
        end

        uacc_pkg::CHARGE_TIMER_ADDR: begin
          next_state.fast_charge_timeout_select = reg_wdata_in[uacc_pkg::TIMEOUT_SEL_LSB +: 3]; // R20
        end

        uacc_pkg::CHARGER_ENABLE_ADDR: begin
          next_state.rapid_charge_enable = reg_wdata_in[uacc_pkg::RAPID_CHARGE_BIT];
          next_state.host_charger_enable = reg_wdata_in[uacc_pkg::HOST_CHG_EN_BIT];
        end

        uacc_pkg::CHARGE_VOLTAGE_ADDR: begin
          next_state.regulation_voltage_select = reg_wdata_in[3:0];
        end

        uacc_pkg::CHARGE_CURRENT_ADDR: begin
          next_state.charge_current_range_bit = reg_wdata_in[uacc_pkg::CURRENT_RANGE_BIT];
          next_state.charge_current_high_field = reg_wdata_in[3:0];
        end

        default: begin
        end
      endcase
    end

    // Interrupt follows the next flag and mask values so it moves with them
    next_state.irq = |(next_state.accessory_event_flags & next_state.accessory_event_mask) || // R3 R19
                     |(next_state.charger_event_flags & next_state.charger_event_mask); // R4 R19

    kind_auto = (charger_kind_code_in >= uacc_pkg::KIND_AUTO_LO) &&
                (charger_kind_code_in <= uacc_pkg::KIND_AUTO_HI); // R12
    if (!usb_compliance_flag_in && charger_kind_code_in == uacc_pkg::KIND_USB_PORT) begin
      kind_auto = 1'b1; // R13
    end
    next_state.charger_on = next_state.host_charger_enable && !charger_detection_running_in && kind_auto; // R12

    case (next_state.fast_charge_timeout_select)
      uacc_pkg::TIMEOUT_6H_CODE: next_state.timeout_hours = uacc_pkg::TIMEOUT_6H; // R10
      uacc_pkg::TIMEOUT_7H_CODE: next_state.timeout_hours = uacc_pkg::TIMEOUT_7H; // R10
      uacc_pkg::TIMEOUT_OFF_CODE: next_state.timeout_hours = 4'h0; // R10
      default: next_state.timeout_hours = uacc_pkg::TIMEOUT_5H; // R10
    endcase

    if (next_state.regulation_voltage_select == 4'h0) begin
      next_state.cv_mv = uacc_pkg::CV_DEFAULT_MV; // R14

    end else if (next_state.regulation_voltage_select <= uacc_pkg::CV_LOW_LAST) begin
      next_state.cv_mv = uacc_pkg::CV_LOW_BASE_MV + 13'(uacc_pkg::CV_STEP_MV *
                         13'(next_state.regulation_voltage_select - 4'h1)); // R14
    end else if (next_state.regulation_voltage_select == uacc_pkg::CV_MAX_CODE) begin
      next_state.cv_mv = uacc_pkg::CV_MAX_MV; // R14

    end else begin
      next_state.cv_mv = uacc_pkg::CV_HIGH_BASE_MV + 13'(uacc_pkg::CV_STEP_MV *
                         13'(next_state.regulation_voltage_select - uacc_pkg::CV_HIGH_FIRST)); // R14
    end

    if (next_state.charge_current_range_bit) begin
      next_state.current_ma = uacc_pkg::CURRENT_BASE_MA + 10'(uacc_pkg::CURRENT_STEP_MA *
                              10'(next_state.charge_current_high_field)); // R16
    end else begin
      next_state.current_ma = uacc_pkg::CURRENT_TRICKLE_MA; // R15
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
      state.accessory_event_mask <= uacc_pkg::EVENT_MASK_RST; // R18
      state.charger_event_mask <= uacc_pkg::EVENT_MASK_RST; // R18

      {state.spare_ctrl, state.adc_debounce_select, state.status_lamp_override,
       state.fixture_output_override} <= uacc_pkg::DEBOUNCE_OVERRIDE_RST;

      state.fast_charge_timeout_select <= uacc_pkg::TIMEOUT_SEL_RST; // R10
      state.rapid_charge_enable <= uacc_pkg::RAPID_CHARGE_RST; // R11
      state.host_charger_enable <= uacc_pkg::HOST_CHG_EN_RST;

      state.regulation_voltage_select <= uacc_pkg::VOLTAGE_SEL_RST;
      state.charge_current_range_bit <= uacc_pkg::CURRENT_RANGE_RST; // R15
      state.charge_current_high_field <= uacc_pkg::CURRENT_HIGH_RST; // R16

      state.timeout_hours <= uacc_pkg::TIMEOUT_5H;
      state.cv_mv <= uacc_pkg::CV_DEFAULT_MV;
      state.current_ma <= 10'd450;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_out = state.rdata;

  assign irq_n_out = ~state.irq;

  assign adc_debounce_select_out = state.adc_debounce_select;

  assign charger_enable_out = state.charger_on;
  assign fast_charge_permit_out = state.rapid_charge_enable; // R11

  assign fast_charge_timeout_hours_out = state.timeout_hours;
  assign fast_charge_timer_off_out = state.timeout_hours == 4'h0;

  assign regulation_millivolts_out = state.cv_mv;
  assign charge_current_ma_out = state.current_ma;

  // Both pins are open drain: they only ever pull low
  assign lamp_out = 1'b0;
  assign fixture_out = 1'b0;

  always_comb begin
    case (state.status_lamp_override)
      uacc_pkg::OVR_AUTO: lamp_oe_n_out = ~lamp_auto_low_in; // R8
      uacc_pkg::OVR_ONE: lamp_oe_n_out = 1'b0; // R8
      default: lamp_oe_n_out = 1'b1; // R8
    endcase
  end

  always_comb begin
    case (state.fixture_output_override)
      uacc_pkg::OVR_AUTO: fixture_oe_n_out = ~dbnc.held; // R9 R17
      uacc_pkg::OVR_ONE: fixture_oe_n_out = 1'b1; // R9
      default: fixture_oe_n_out = 1'b0; // R9
    endcase
  end

endmodule : uacc_regs

/* uacc_regs_properties.sv */
// Purpose: Port-level properties of the register bank
// Assumes: One clock, asynchronous active-high reset
// Notes: Sees only top ports; bound below
`timescale 1ns/1ps

module uacc_regs_properties (
  input logic ref_clk_in,
  input logic sys_rst_in,
  input logic [7:0] reg_addr_in,
  input logic reg_wr_in,
  input logic [7:0] reg_wdata_in,
  input logic reg_rd_in,
  input logic [7:0] reg_rdata_out,
  input logic [2:0] charger_kind_code_in,
  input logic charger_detection_running_in,
  input logic usb_compliance_flag_in,
  input logic irq_n_out,
  input logic lamp_oe_n_out,
  input logic fixture_oe_n_out,
  input logic [1:0] adc_debounce_select_out,
  input logic charger_enable_out,
  input logic [3:0] fast_charge_timeout_hours_out,
  input logic fast_charge_timer_off_out,
  input logic [12:0] regulation_millivolts_out,
  input logic [9:0] charge_current_ma_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ========
  // Helpers
  logic mask_seen;
  wire w0e = reg_wr_in && reg_addr_in == 8'h0E;
  wire w0f = reg_wr_in && reg_addr_in == 8'h0F;
  wire w11 = reg_wr_in && reg_addr_in == 8'h11;
  wire w12 = reg_wr_in && reg_addr_in == 8'h12;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) mask_seen <= 1'b0;
    else if (reg_wr_in && (reg_addr_in == 8'h07 || reg_addr_in == 8'h09)) mask_seen <= 1'b1;
  end
  // ========
  // Properties
  property p_irq_masked; !mask_seen |-> irq_n_out; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("early irq");
  property p_dbnc; w0e |=> adc_debounce_select_out == $past(reg_wdata_in[5:4]); endproperty
  a_dbnc: assert property (p_dbnc) else $error("bad debounce");
  property p_lamp_low; w0e && reg_wdata_in[3:2] == 2'h1 |=> !lamp_oe_n_out; endproperty
  a_lamp_low: assert property (p_lamp_low) else $error("lamp not pulled low");
  property p_fix_hiz; w0e && reg_wdata_in[1:0] == 2'h1 |=> fixture_oe_n_out; endproperty
  a_fix_hiz: assert property (p_fix_hiz) else $error("fixture not released");
  property p_timer_off; w0f && reg_wdata_in[6:4] == 3'h7
    |-> ##[1:2] fast_charge_timer_off_out && fast_charge_timeout_hours_out == 4'h0; endproperty
  a_timer_off: assert property (p_timer_off) else $error("timer not disabled");
  property p_cv_top; w11 && reg_wdata_in[3:0] == 4'hF |-> ##[1:2] regulation_millivolts_out == 13'h10FE; endproperty
  a_cv_top: assert property (p_cv_top) else $error("top voltage wrong");
  property p_trickle; w12 && !reg_wdata_in[4] |-> ##[1:2] charge_current_ma_out == 10'h05A; endproperty
  a_trickle: assert property (p_trickle) else $error("bad trickle");
  property p_unmapped; reg_rd_in && reg_addr_in == 8'h20 |=> reg_rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_chg_on; $rose(charger_enable_out) |-> $past(!charger_detection_running_in
    && (charger_kind_code_in inside {[3'h2:3'h5]} || (charger_kind_code_in == 3'h1 && !usb_compliance_flag_in)));
  endproperty
  a_chg_on: assert property (p_chg_on) else $error("bad charger on");
endmodule : uacc_regs_properties

bind uacc_regs uacc_regs_properties u_props (.*);

/* usb_accessory_charger_ctrl_regs_tb_top.sv */
// Purpose: Self-checking bench for the register bank
// Assumes: Debounce counts shrunk to 4/8/12/16 cycles
// Notes: Expectations come from the rules
`timescale 1ns/1ps

module usb_accessory_charger_ctrl_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wd, rdata, sa = 8'h00, sc = 8'h00, d, ec;
  logic wr, rd, det = 1'b0, usbc = 1'b0, lamp_a = 1'b0, fix_a = 1'b0;
  logic [2:0] kind = 3'h0;
  logic irq_n, lamp, lamp_oe_n, fix, fix_oe_n, chg_en, permit, toff;
  logic [1:0] dsel;
  logic [3:0] hrs;
  logic [12:0] mv;
  logic [9:0] ma;
  logic [31:0] seed = 32'h0001553C;
  logic [7:0] ra[8] = '{8'h07, 8'h09, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h20};
  logic [7:0] rr[8] = '{8'h00, 8'h00, 8'h00, 8'h24, 8'hD4, 8'hA0, 8'h15, 8'h00};
  logic [7:0] rm[8] = '{8'hFF, 8'hFF, 8'hFF, 8'h70, 8'hC0, 8'h0F, 8'h1F, 8'h00};
  int errors = 0, checked = 0, cyc = 0, n;
  uacc_regs #(.DBNC0_CYC(4), .DBNC1_CYC(8), .DBNC2_CYC(12), .DBNC3_CYC(16)) dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .accessory_status_a_in(sa), .accessory_status_c_in(sc),
    .charger_kind_code_in(kind), .charger_detection_running_in(det), .usb_compliance_flag_in(usbc),
    .lamp_auto_low_in(lamp_a), .fixture_auto_low_in(fix_a), .irq_n_out(irq_n), .lamp_out(lamp),
    .lamp_oe_n_out(lamp_oe_n), .fixture_out(fix), .fixture_oe_n_out(fix_oe_n),
    .adc_debounce_select_out(dsel), .charger_enable_out(chg_en), .fast_charge_permit_out(permit),
    .fast_charge_timeout_hours_out(hrs), .fast_charge_timer_off_out(toff),
    .regulation_millivolts_out(mv), .charge_current_ma_out(ma));
  uacc_host host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .wdata_out(wd), .rd_out(rd), .rdata_in(rdata));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      wrap_up();
    end
  end
  // ========
  // Reference model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int exp_mv(int c);
    if (c == 0) return 4200;
    if (c <= 10) return 3980 + 20 * c;
    if (c <= 14) return 4000 + 20 * c;
    return 4350;
  endfunction : exp_mv
  task automatic chk(input string nm, input int e, input logic [12:0] g);
    checked++;
    if (g !== e[12:0]) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd_reg(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rdchk
  task automatic st();
    repeat (3) @(posedge clk);
    #1;
  endtask : st
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // ========
  // Scenarios
  initial begin
    logic [31:0] v;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdchk(ra[i], rr[i]);
      v = rnd();
      host.wr_reg(ra[i], v[7:0]);
      rdchk(ra[i], (v[7:0] & rm[i]) | (rr[i] & ~rm[i]));
      host.wr_reg(ra[i], rr[i]);
    end
    $display("test registers done");
    for (int c = 0; c < 32; c++) begin
      host.wr_reg(8'h0F, {1'b0, c[2:0], 4'h0});
      host.wr_reg(8'h11, {4'h0, c[3:0]});
      host.wr_reg(8'h12, {3'h0, c[4], c[3:0]});
      st();
      chk("hours", c[2:0] == 3 ? 6 : c[2:0] == 4 ? 7 : c[2:0] == 7 ? 0 : 5, hrs);
      chk("timer_off", c[2:0] == 7, toff);
      chk("millivolts", exp_mv(c[3:0]), mv);
      chk("milliamps", c[4] ? 200 + 50 * c[3:0] : 90, ma);
    end
    $display("test charge fields done");
    for (int c = 0; c < 8; c++) begin
      lamp_a = c[2];
      host.wr_reg(8'h0E, {4'h0, c[1:0], c[1:0]});
      st();
      chk("lamp_oe_n", c[1:0] == 0 ? !c[2] : c[1], lamp_oe_n);
      chk("fixture_oe_n", !c[1], fix_oe_n);
      chk("lamp", 0, lamp);
      chk("fixture", 0, fix);
    end
    $display("test overrides done");
    for (int s = 0; s < 4; s++) begin
      host.wr_reg(8'h0E, {2'h0, s[1:0], 4'h0});
      st();
      chk("debounce_select", s, dsel);
      fix_a = 1'b1;
      n = 0;
      while (fix_oe_n !== 1'b0 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("fixture_delay", n >= 4 * (s + 1) && n <= 4 * (s + 1) + 2, 1);
      fix_a = 1'b0;
      st();
      chk("fixture_release", 1, fix_oe_n);
    end
    $display("test debounce done");
    host.wr_reg(8'h09, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      v = rnd();
      host.wr_reg(8'h07, k < 4 ? 8'hFF : 8'h00);
      d = v[7:0] | 8'h01;
      ec = {v[15:9], v[18:16] != kind};
      sa = sa ^ d;
      sc = sc ^ {v[15:9], 1'b0};
      kind = v[18:16];
      st();
      chk("irq_n", k >= 4 && ec == 0, irq_n);
      rdchk(8'h01, d);
      chk("irq_n", ec == 0, irq_n);
      rdchk(8'h03, ec);
      chk("irq_n", 1, irq_n);
      rdchk(8'h01, 8'h00);
    end
    $display("test events done");
    for (int c = 0; c < 32; c++) begin
      kind = c[2:0];
      usbc = c[3];
      det = c[4];
      st();
      chk("charger_on", !c[4] && (c[2:0] inside {[2:5]} || (c[2:0] == 1 && !c[3])), chg_en);
    end
    det = 1'b0;
    kind = 3'h2;
    host.wr_reg(8'h10, 8'h00);
    st();
    chk("charger_on", 0, chg_en);
    chk("permit", 0, permit);
    host.wr_reg(8'h10, 8'hC0);
    st();
    chk("charger_on", 1, chg_en);
    chk("permit", 1, permit);
    $display("test charger enable done");
    wrap_up();
  end
endmodule : usb_accessory_charger_ctrl_regs_tb_top
